// ### irsl_pkg.sv
// Package of constants, carriers and states for the internal reset logic.
package irsl_pkg;

   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [7:0] ADDR_RSR    = 8'h00;
   localparam logic [7:0] ADDR_WDCTL  = 8'h04;
   localparam logic [7:0] ADDR_WDLIM  = 8'h08;
   localparam logic [7:0] ADDR_IRQST  = 8'h0c;
   localparam logic [7:0] ADDR_IRQMSK = 8'h10;

   // Field positions in the reset source register.
   localparam int RSR_SW  = 4;
   localparam int RSR_WD  = 5;
   localparam int RSR_MEM = 6;
   localparam int RSR_USB = 7;

   // Field positions in the watchdog control register.
   localparam int WDCTL_EN  = 0;
   localparam int WDCTL_SVC = 1;

   // Event positions in the interrupt status and mask registers.
   localparam int IRQ_W   = 4;
   localparam int EV_WD   = 0;
   localparam int EV_MEM  = 1;
   localparam int EV_SW   = 2;
   localparam int EV_USB  = 3;

   // Watchdog clock divider and timeout reset value.
   localparam int         WD_DIV       = 12;
   localparam logic [3:0] WD_DIV_LAST  = 4'(WD_DIV - 1);
   localparam logic [15:0] WD_LIMIT_RST = 16'hffff;

   // Length of the system reset pulse, in cycles, and its last count.
   localparam int         RST_PULSE_CYC  = 4;
   localparam logic [2:0] RST_PULSE_LAST = 3'(RST_PULSE_CYC - 1);

   // Reset values of control registers.
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Requests from the program memory controller.
   typedef struct packed {
      logic prog_write_above;  // Programmer write or erase above limit.
      logic table_read_above;  // Code table read above limit.
      logic fetch_above;       // Instruction fetch above limit.
      logic security_block;    // Access forbidden by memory security.
      logic write_erase_req;   // A write or erase is being attempted.
      logic supply_monitor_on; // Supply monitor is enabled.
   } irsl_pm_t;

   // Inputs from the USB function controller and bus power sense pin.
   typedef struct packed {
      logic bus_reset_seen;    // Bus reset signalling detected.
      logic controller_on;     // Function controller enabled.
      logic bus_power;         // Level of the bus power sense pin.
   } irsl_usb_t;

   // Sequencer states.
   typedef enum logic [0:0] {ST_RUN, ST_RESET} irsl_state_t;

endpackage : irsl_pkg

// ### irsl_watchdog.sv
// Watchdog counter on the system clock divided by twelve.
`timescale 1ns/1ps
`default_nettype none
module irsl_watchdog
   import irsl_pkg::*;
(
   input  wire logic        aclk,     // System clock.
   input  wire logic        aresetn,  // Synchronous reset, active low.
   input  wire logic        restart,  // Held while the system is in reset.
   input  wire logic        enable,   // Counting enabled.
   input  wire logic        service,  // Software restarts the count.
   input  wire logic [15:0] limit,    // Tick count at which it expires.
   output logic             expire    // One-cycle timeout pulse.
);

   logic [3:0]  div;        // Prescaler position.
   logic [15:0] count;      // Divided ticks counted so far.
   logic [3:0]  next_div;   // Next prescaler position.
   logic [15:0] next_count; // Next tick count.
   logic        next_expire;// Next timeout pulse.

   // Divides by twelve and counts ticks up to the limit.
   always_comb begin
      next_div    = div;
      next_count  = count;
      next_expire = 1'b0;
      if (restart || service || !enable) begin
         next_div   = 4'h0;
         next_count = 16'h0000;
      end else if (div == WD_DIV_LAST) begin
         next_div = 4'h0;
         if (count == limit) begin
            next_count  = 16'h0000;
            next_expire = 1'b1;
         end else begin
            next_count = count + 16'h0001;
         end
      end else begin
         next_div = div + 4'h1;
      end
   end

   // Registers the counter state.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div    <= 4'h0;
         count  <= 16'h0000;
         expire <= 1'b0;
      end else begin
         div    <= next_div;
         count  <= next_count;
         expire <= next_expire;
      end
   end

   // The prescaler never passes its last count of eleven.
   chk_prescale_wrap : assert property (@(posedge aclk) disable iff (!aresetn)
      div <= WD_DIV_LAST) else $error("watchdog prescaler overran");

endmodule : irsl_watchdog
`default_nettype wire

// ### irsl_top.sv
// Internal reset source collector with AXI4-Lite registers.
//
// Contract
// - Watchdog enabled, clocked at clock/12 after reset.
// - Watchdog timeout resets and sets bit 5.
// - Internal resets never drive the reset pin.
// - Accesses above code limit cause reset.
// - Security-forbidden memory access causes reset.
// - Write/erase with supply monitor off resets.
// - Memory error reset sets bit 6.
// - Writing one to bit 4 forces reset.
// - Software reset flag reads one afterwards.
// - USB select bit enables USB reset source.
// - Selected, enabled USB bus reset resets.
// - Selected, bus power edge either way resets.
// - USB flag reads one after USB reset.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module irsl_top
   import irsl_pkg::*;
(
   input  wire logic        aclk,           // System clock, 25 MHz.
   input  wire logic        aresetn,        // Synchronous reset, active low.
   input  wire logic [7:0]  s_axi_awaddr,   // Write address.
   input  wire logic        s_axi_awvalid,  // Write address valid.
   output logic             s_axi_awready,  // Write address ready.
   input  wire logic [31:0] s_axi_wdata,    // Write data.
   input  wire logic [3:0]  s_axi_wstrb,    // Write byte enables.
   input  wire logic        s_axi_wvalid,   // Write data valid.
   output logic             s_axi_wready,   // Write data ready.
   output logic [1:0]       s_axi_bresp,    // Write response.
   output logic             s_axi_bvalid,   // Write response valid.
   input  wire logic        s_axi_bready,   // Write response ready.
   input  wire logic [7:0]  s_axi_araddr,   // Read address.
   input  wire logic        s_axi_arvalid,  // Read address valid.
   output logic             s_axi_arready,  // Read address ready.
   output logic [31:0]      s_axi_rdata,    // Read data.
   output logic [1:0]       s_axi_rresp,    // Read response.
   output logic             s_axi_rvalid,   // Read data valid.
   input  wire logic        s_axi_rready,   // Read data ready.
   input  wire irsl_pm_t    pm,             // Program memory requests.
   input  wire irsl_usb_t   usb,            // USB and bus power inputs.
   output logic             system_reset_n, // System reset, active low.
   output logic             pm_write_inhibit, // Blocks write or erase.
   output logic             reset_pin_oe,   // External reset pin drive.
   output logic             irq             // Level interrupt request.
);

   irsl_state_t      state;          // Sequencer state.
   logic [2:0]       pulse_cnt;      // Cycles spent in reset.
   logic             flag_wd;        // Watchdog caused last reset.
   logic             flag_mem;       // Memory error caused last reset.
   logic             flag_sw;        // Software caused last reset.
   logic             flag_usb;       // USB caused last reset.
   logic             usb_select;     // USB selected as reset source.
   logic             wd_en;          // Watchdog enable.
   logic [15:0]      wd_limit;       // Watchdog timeout in ticks.
   logic [IRQ_W-1:0] irq_status;     // Sticky event bits.
   logic [IRQ_W-1:0] irq_mask;       // Interrupt mask.
   logic             bus_power_q;    // Previous bus power level.
   logic             bus_power_ok;   // Previous level is valid.
   logic             sw_req;         // Software reset request pulse.
   logic             wd_service;     // Watchdog service pulse.
   logic             wd_expire;      // Watchdog timeout pulse.
   logic             aw_held;        // Write address captured.
   logic             w_held;         // Write data captured.
   logic [7:0]       aw_addr;        // Captured write address.
   logic [31:0]      w_data;         // Captured write data.
   logic [3:0]       w_strb;         // Captured byte enables.

   irsl_state_t      next_state;
   logic [2:0]       next_pulse_cnt;
   logic             next_flag_wd, next_flag_mem, next_flag_sw;
   logic             next_flag_usb, next_usb_select, next_wd_en;
   logic [15:0]      next_wd_limit;
   logic [IRQ_W-1:0] next_irq_status, next_irq_mask;
   logic             next_bus_power_q, next_bus_power_ok;
   logic             next_sw_req, next_wd_service;
   logic             next_aw_held, next_w_held;
   logic [7:0]       next_aw_addr;
   logic [31:0]      next_w_data;
   logic [3:0]       next_w_strb;
   logic             next_awready, next_wready, next_bvalid;
   logic [1:0]       next_bresp;
   logic             next_arready, next_rvalid;
   logic [1:0]       next_rresp;
   logic [31:0]      next_rdata;

   logic             mem_err;        // Any program memory error.
   logic             bus_edge;       // Bus power changed level.
   logic             usb_req;        // USB source asks for reset.
   logic             any_req;        // Some source asks for reset.
   logic             do_write;       // Captured write is applied now.
   logic             do_read;        // Read address taken now.
   logic             in_reset;       // System is held in reset.

   // Tells whether an offset names a mapped register.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ADDR_RSR) || (a == ADDR_WDCTL) || (a == ADDR_WDLIM)
            || (a == ADDR_IRQST) || (a == ADDR_IRQMSK);
   endfunction : mapped

   // Watchdog counter, restarted through every system reset.
   irsl_watchdog u_wd (
      .aclk    (aclk),
      .aresetn (aresetn),
      .restart (in_reset),
      .enable  (wd_en),
      .service (wd_service),
      .limit   (wd_limit),
      .expire  (wd_expire)
   );

   // Reset request sources and bus handshakes.
   always_comb begin
      in_reset = (state == ST_RESET);
      mem_err  = pm.prog_write_above || pm.table_read_above
              || pm.fetch_above
              || pm.security_block
              || (pm.write_erase_req && !pm.supply_monitor_on);
      bus_edge = bus_power_ok && (usb.bus_power != bus_power_q);
      usb_req  = usb_select
              && ((usb.bus_reset_seen && usb.controller_on)
                  || bus_edge);
      any_req  = wd_expire || mem_err || sw_req || usb_req;
      do_write = aw_held && w_held && !s_axi_bvalid;
      do_read  = s_axi_arvalid && s_axi_arready;
   end

   // Sequencer: captures causes, then holds the system in reset.
   always_comb begin
      next_state     = state;
      next_pulse_cnt = pulse_cnt;
      next_flag_wd   = flag_wd;
      next_flag_mem  = flag_mem;
      next_flag_sw   = flag_sw;
      next_flag_usb  = flag_usb;
      case (state)
         ST_RUN: begin
            if (any_req) begin
               next_state     = ST_RESET;
               next_pulse_cnt = 3'h0;
               next_flag_wd   = wd_expire;
               next_flag_mem  = mem_err;
               next_flag_sw   = sw_req;
               next_flag_usb  = usb_req;
            end
         end
         ST_RESET: begin
            if (pulse_cnt == RST_PULSE_LAST) begin
               next_state = ST_RUN;
            end else begin
               next_pulse_cnt = pulse_cnt + 3'h1;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // Register file writes, events and the bus power edge detector.
   always_comb begin
      next_usb_select   = usb_select;
      next_wd_en        = wd_en;
      next_wd_limit     = wd_limit;
      next_irq_mask     = irq_mask;
      next_irq_status   = irq_status;
      next_sw_req       = 1'b0;
      next_wd_service   = 1'b0;
      next_bus_power_q  = usb.bus_power;
      next_bus_power_ok = 1'b1;
      if (do_write && w_strb[0]) begin
         case (aw_addr)
            ADDR_RSR: begin
               next_usb_select = w_data[RSR_USB];
               next_sw_req     = w_data[RSR_SW];
            end
            ADDR_WDCTL: begin
               next_wd_en      = w_data[WDCTL_EN];
               next_wd_service = w_data[WDCTL_SVC];
            end
            ADDR_WDLIM: begin
               next_wd_limit[7:0] = w_data[7:0];
            end
            ADDR_IRQMSK: begin
               next_irq_mask = w_data[IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      if (do_write && w_strb[1] && aw_addr == ADDR_WDLIM) begin
         next_wd_limit[15:8] = w_data[15:8];
      end
      if (in_reset) begin
         next_wd_en = 1'b1;
      end
      // Reading the status clears it; a reset request in run that cycle keeps all old bits and adds its own.
      if (do_read && s_axi_araddr == ADDR_IRQST) begin
         next_irq_status = '0;
      end
      if (state == ST_RUN && any_req) begin
         next_irq_status[EV_WD]  = irq_status[EV_WD] | wd_expire;
         next_irq_status[EV_MEM] = irq_status[EV_MEM] | mem_err;
         next_irq_status[EV_SW]  = irq_status[EV_SW] | sw_req;
         next_irq_status[EV_USB] = irq_status[EV_USB] | usb_req;
      end
   end

   // AXI4-Lite write and read channels.
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rresp   = s_axi_rresp;
      next_rdata   = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_read) begin
         next_rvalid = 1'b1;
         next_rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         next_rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            ADDR_RSR: begin
               next_rdata[RSR_SW]  = flag_sw;
               next_rdata[RSR_WD]  = flag_wd;
               next_rdata[RSR_MEM] = flag_mem;
               next_rdata[RSR_USB] = usb_select | flag_usb;
            end
            ADDR_WDCTL:  next_rdata[WDCTL_EN] = wd_en;
            ADDR_WDLIM:  next_rdata[15:0] = wd_limit;
            ADDR_IRQST:  next_rdata[IRQ_W-1:0] = irq_status;
            ADDR_IRQMSK: next_rdata[IRQ_W-1:0] = irq_mask;
            default: begin
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   // Registers all state and drives the outputs from flops.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state            <= ST_RUN;
         pulse_cnt        <= 3'h0;
         flag_wd          <= 1'b0;
         flag_mem         <= 1'b0;
         flag_sw          <= 1'b0;
         flag_usb         <= 1'b0;
         usb_select       <= 1'b0;
         wd_en            <= 1'b1;
         wd_limit         <= WD_LIMIT_RST;
         irq_status       <= '0;
         irq_mask         <= IRQ_MASK_RST;
         bus_power_q      <= 1'b0;
         bus_power_ok     <= 1'b0;
         sw_req           <= 1'b0;
         wd_service       <= 1'b0;
         aw_held          <= 1'b0;
         w_held           <= 1'b0;
         aw_addr          <= 8'h00;
         w_data           <= 32'h0000_0000;
         w_strb           <= 4'h0;
         s_axi_awready    <= 1'b0;
         s_axi_wready     <= 1'b0;
         s_axi_bvalid     <= 1'b0;
         s_axi_bresp      <= RESP_OKAY;
         s_axi_arready    <= 1'b0;
         s_axi_rvalid     <= 1'b0;
         s_axi_rresp      <= RESP_OKAY;
         s_axi_rdata      <= 32'h0000_0000;
         system_reset_n   <= 1'b0;
         pm_write_inhibit <= 1'b1;
         reset_pin_oe     <= 1'b0;
         irq              <= 1'b0;
      end else begin
         state            <= next_state;
         pulse_cnt        <= next_pulse_cnt;
         flag_wd          <= next_flag_wd;
         flag_mem         <= next_flag_mem;
         flag_sw          <= next_flag_sw;
         flag_usb         <= next_flag_usb;
         usb_select       <= next_usb_select;
         wd_en            <= next_wd_en;
         wd_limit         <= next_wd_limit;
         irq_status       <= next_irq_status;
         irq_mask         <= next_irq_mask;
         bus_power_q      <= next_bus_power_q;
         bus_power_ok     <= next_bus_power_ok;
         sw_req           <= next_sw_req;
         wd_service       <= next_wd_service;
         aw_held          <= next_aw_held;
         w_held           <= next_w_held;
         aw_addr          <= next_aw_addr;
         w_data           <= next_w_data;
         w_strb           <= next_w_strb;
         s_axi_awready    <= next_awready;
         s_axi_wready     <= next_wready;
         s_axi_bvalid     <= next_bvalid;
         s_axi_bresp      <= next_bresp;
         s_axi_arready    <= next_arready;
         s_axi_rvalid     <= next_rvalid;
         s_axi_rresp      <= next_rresp;
         s_axi_rdata      <= next_rdata;
         system_reset_n   <= (next_state != ST_RESET);
         pm_write_inhibit <= !pm.supply_monitor_on;
         reset_pin_oe     <= 1'b0;
         irq              <= |(next_irq_status & next_irq_mask);
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // A request taken in run opens a reset pulse of exactly four cycles.
   sequence s_pulse;
      !system_reset_n [*4] ##1 system_reset_n;
   endsequence

   chk_pulse_length : assert property (
      state == ST_RUN && any_req |-> ##1 s_pulse)
      else $error("reset pulse length wrong");
   chk_wd_cause : assert property (
      state == ST_RUN && wd_expire |-> ##1 flag_wd && !system_reset_n)
      else $error("watchdog timeout not recorded");
   chk_mem_cause : assert property (
      state == ST_RUN && mem_err |-> ##1 flag_mem && !system_reset_n)
      else $error("memory error not recorded");
   chk_limit_access : assert property (
      state == ST_RUN && (pm.fetch_above || pm.table_read_above)
      |-> ##1 !system_reset_n) else $error("limit access not reset");
   chk_supply_off : assert property (
      state == ST_RUN && pm.write_erase_req && !pm.supply_monitor_on
      |-> ##1 flag_mem) else $error("write with monitor off not reset");
   chk_sw_force : assert property (
      do_write && w_strb[0] && aw_addr == ADDR_RSR && w_data[RSR_SW]
      && state == ST_RUN && !any_req |-> ##2 flag_sw && !system_reset_n)
      else $error("software reset not forced");
   chk_usb_gate : assert property (
      !usb_select && state == ST_RUN && !wd_expire && !mem_err && !sw_req
      |-> ##1 system_reset_n) else $error("unselected usb caused reset");
   chk_usb_bus : assert property (
      state == ST_RUN && usb_select && usb.bus_reset_seen
      && usb.controller_on |-> ##1 flag_usb)
      else $error("usb bus reset missed");
   chk_power_edge : assert property (
      state == ST_RUN && usb_select && bus_power_ok
      && $changed(usb.bus_power) |-> ##1 flag_usb)
      else $error("bus power edge missed");
   chk_wd_reenable : assert property (
      $rose(system_reset_n) |-> wd_en) else $error("watchdog not enabled");
   chk_pin_quiet : assert property (
      !reset_pin_oe) else $error("reset pin driven");

endmodule : irsl_top
`default_nettype wire

// ### irsl_far_side.sv
// Far-side model of the memory controller and USB function controller.
`timescale 1ns/1ps
`default_nettype none
module irsl_far_side
   import irsl_pkg::*;
(
   input  wire logic       aclk,    // System clock.
   input  wire logic       aresetn, // Synchronous reset, active low.
   input  wire logic [2:0] cmd,     // Event code, held one cycle.
   output var  irsl_pm_t   pm,      // Program memory request levels.
   output var  irsl_usb_t  usb      // USB and bus power levels.
);
   // Idle keeps the supply monitor on; each code raises one event.
   always_ff @(posedge aclk) begin
      pm.prog_write_above  <= (cmd == 3'd1);
      pm.table_read_above  <= (cmd == 3'd2);
      pm.fetch_above       <= (cmd == 3'd3);
      pm.security_block    <= (cmd == 3'd4);
      pm.write_erase_req   <= (cmd == 3'd5);
      pm.supply_monitor_on <= (cmd != 3'd5);
      usb.controller_on    <= 1'b1;
      usb.bus_reset_seen   <= (cmd == 3'd6);
      // The sense level moves only on a toggle, so each toggle is one edge.
      usb.bus_power <= aresetn & (usb.bus_power ^ (cmd == 3'd7));
   end
endmodule : irsl_far_side
`default_nettype wire

// ### irsl_bench.sv
// Self-checking bench for the internal reset source logic.
`timescale 1ns/1ps
`default_nettype none
module irsl_bench;
   import irsl_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, d;
   logic [1:0]  bresp, rresp, r;
   logic [2:0]  cmd = '0;  // Far-side event code.
   logic        sys_n, pin_oe, irq, inh;
   irsl_pm_t    pm;
   irsl_usb_t   usb;
   int          fails = 0, checks = 0, lat, lim, lows = 0, base;
   // Clock of 40 ns; low cycles of the system reset are counted.
   always #20 aclk = ~aclk;
   always @(posedge aclk) if (sys_n === 1'b0) lows++;
   irsl_far_side far (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .pm(pm),
      .usb(usb));
   irsl_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pm(pm), .usb(usb),
      .system_reset_n(sys_n), .pm_write_inhibit(inh), .reset_pin_oe(pin_oe),
      .irq(irq));
   // Compares one value and reports a mismatch at once.
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One AXI4-Lite write; each channel is released when it is taken.
   // The response ready is left high, so back-to-back calls never assign
   // it twice within one time step.
   task automatic wr(logic [7:0] a, logic [31:0] v);
      int n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 50);
      r = bresp;
   endtask : wr
   // One AXI4-Lite read; data and response land in d and r.
   task automatic rd(logic [7:0] a);
      int n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 50);
      d = rdata;
      r = rresp;
   endtask : rd
   // Raises an event, waits for the reset pulse and measures it.
   task automatic ev(logic [2:0] c);
      int n = 0;
      cmd <= c;
      lat = 0;
      while (sys_n !== 1'b0 && lat < 200) begin
         @(posedge aclk);
         cmd <= 3'd0;
         lat++;
      end
      while (sys_n === 1'b0 && n < 9) begin
         chk("pin_oe", 0, pin_oe);
         if (n == 0) chk("inhibit", 32'(c == 3'd5), inh);
         @(posedge aclk);
         n++;
      end
      chk("pulse_len", 4, n);
   endtask : ev
   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      results();
   end
   // Main sequence of tests.
   initial begin
      d = $urandom(32'h818e4ba9);
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(ADDR_WDCTL);
      chk("wd_en", 1, d[WDCTL_EN]);
      rd(ADDR_WDLIM);
      chk("wd_lim", 32'(WD_LIMIT_RST), d);
      rd(8'h14);
      chk("unmapped", 32'(RESP_SLVERR), 32'(r));
      $display("test reset values done");
      for (int k = 1; k <= 5; k++) begin
         ev(3'(k));
         rd(ADDR_RSR);
         chk("mem_flag", 32'h40, d & 32'hf0);
      end
      $display("test memory errors done");
      wr(ADDR_RSR, 32'h10);
      ev(3'd0);
      rd(ADDR_RSR);
      chk("sw_flag", 32'h10, d & 32'hf0);
      $display("test software reset done");
      base = lows;
      cmd <= 3'd7;
      @(posedge aclk);
      cmd <= 3'd0;
      repeat (10) @(posedge aclk);
      chk("usb_unsel", base, lows);
      wr(ADDR_RSR, 32'h80);
      for (int k = 0; k < 3; k++) begin
         ev(k == 0 ? 3'd6 : 3'd7);
         rd(ADDR_RSR);
         chk("usb_flag", 32'h80, d & 32'hf0);
      end
      wr(ADDR_RSR, 32'h00);
      chk("bresp", 32'(RESP_OKAY), 32'(r));
      rd(ADDR_RSR);
      chk("usb_cause", 32'h80, d & 32'hf0);
      $display("test usb reset done");
      lim = $urandom % 4 + 1;
      wr(ADDR_WDLIM, 32'(lim));
      wr(ADDR_WDCTL, 32'h3);
      ev(3'd0);
      base = (lim + 1) * WD_DIV;
      chk("wd_time", 1, 32'(lat >= base - 14 && lat <= base + 4));
      rd(ADDR_RSR);
      chk("wd_flag", 32'h20, d & 32'hf0);
      $display("test watchdog done");
      chk("irq_masked", 0, irq);
      wr(ADDR_IRQMSK, 32'hf);
      @(posedge aclk);
      chk("irq_on", 1, irq);
      rd(ADDR_IRQST);
      chk("irq_status", 32'hf, d);
      repeat (2) @(posedge aclk);
      chk("irq_off", 0, irq);
      $display("test interrupt done");
      results();
   end
endmodule : irsl_bench
`default_nettype wire
